//--- core/spsb_core.sv
// serial port setup block: mode, rate, addresses, error code and reply delay
//
// Overview of operation
// - Port protocol is chosen by a mode code: 0 off, 1 repeater master, 2 repeater slave, 3 ascii, 4 binary.
// - Line rate code 0..9 selects 300 to 115200 baud in order, 9600 after reset.
// - The group address holds only values 0 to 7.
// - The unit address holds values 0 to 255.
// - The latest communication error is readable as a 16-bit code.
// - A write to the error code sets it to the no-error code 00C0, whatever was written, unless a new error arrives in the same cycle.
// - A reply waits a programmable 0 to 255 ms before sending starts.
// - The ascii suppress flag, binary change band and spare word are stored and steer nothing.
`timescale 1ns/10ps
`default_nettype none

module spsb_core
	import spsb_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS
)(
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// link engine side, same clock
	input  wire logic              request_end,
	input  wire logic              reply_start,
	input  wire logic              error_valid,
	input  wire logic [15:0]       error_code_in,
	// configuration to the link engine
	output logic                   port_enable,
	output logic      [2:0]        protocol_mode,
	output logic      [3:0]        baud_code,
	output logic      [DIV_W-1:0]  bit_divisor,
	output logic      [2:0]        group_address,
	output logic      [7:0]        unit_address,
	output logic                   reply_permit,
	output logic                   irq
);

	typedef enum logic [1:0] {
		SPSB_IDLE  = 2'b00,
		SPSB_WAIT  = 2'b01,
		SPSB_READY = 2'b10
	} spsb_state_t;

	localparam logic [31:0] CPM = 32'(CYCLES_PER_MS);

	spsb_state_t state;
	spsb_state_t next_state;

	logic              ascii_suppress_flag;
	logic [15:0]       binary_change_band;
	logic [15:0]       spare_word_seven;
	logic [15:0]       error_report;
	logic [7:0]        reply_delay_ms;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_mask;
	logic [7:0]        ms_left;
	logic [31:0]       tick_cnt;
	logic              delay_done;
	logic              reply_event;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clr;
	logic [DATA_W-1:0] next_rdata;

	// cycles per bit for each rate code; rounds down to whole cycles
	function automatic logic [DIV_W-1:0] rate_divisor(input logic [3:0] code);
		logic [31:0] baud;
		baud = 32'd9600;
		case (code)
			4'h0: baud = 32'd300;
			4'h1: baud = 32'd600;
			4'h2: baud = 32'd1200;
			4'h3: baud = 32'd2400;
			4'h4: baud = 32'd4800;
			4'h5: baud = 32'd9600;
			4'h6: baud = 32'd19200;
			4'h7: baud = 32'd38400;
			4'h8: baud = 32'd57600;
			4'h9: baud = 32'd115200;
			default: baud = 32'd9600;
		endcase
		return DIV_W'(32'(CLK_HZ) / baud);
	endfunction : rate_divisor

	// reset branch must load a plain constant, not a function call
	localparam logic [DIV_W-1:0] RST_DIVISOR = rate_divisor(RST_BAUD);

	function automatic logic wr_hit(input logic [7:0] off);
		return reg_wr && (reg_addr == off);
	endfunction : wr_hit

	// protocol mode; codes above 4 are refused and the old mode stays
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			protocol_mode <= RST_MODE;
		else if (wr_hit(REG_MODE) && reg_wdata[2:0] <= MODE_MAX && reg_wdata[31:3] == '0)
			protocol_mode <= reg_wdata[2:0];
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			port_enable <= 1'b1;
		else if (wr_hit(REG_MODE) && reg_wdata[2:0] <= MODE_MAX && reg_wdata[31:3] == '0)
			port_enable <= (reg_wdata[2:0] != SPSB_MODE_DISABLED);
	end

	// rate code; out of range codes ignored
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			baud_code <= RST_BAUD;
		else if (wr_hit(REG_BAUD) && reg_wdata[3:0] <= BAUD_CODE_MAX && reg_wdata[31:4] == '0)
			baud_code <= reg_wdata[3:0];
	end

	// divisor follows the code one cycle later
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			bit_divisor <= RST_DIVISOR;
		else
			bit_divisor <= rate_divisor(baud_code);
	end

	// addresses; a group value above 7 is refused whole rather than truncated
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			group_address <= RST_GROUP;
		else if (wr_hit(REG_GROUP) && reg_wdata[31:3] == '0)
			group_address <= reg_wdata[2:0] & GROUP_MAX;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			unit_address <= RST_UNIT;
		else if (wr_hit(REG_UNIT) && reg_wdata[31:8] == '0)
			unit_address <= reg_wdata[7:0];
	end

	// held for software only, nothing downstream reads them
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ascii_suppress_flag <= RST_SUPPRESS;
			binary_change_band  <= RST_CHANGE_BAND;
			spare_word_seven    <= RST_SPARE;
		end
		else
		begin
			if (wr_hit(REG_SUPPRESS))
				ascii_suppress_flag <= reg_wdata[0];
			if (wr_hit(REG_CHANGE_BAND) && reg_wdata[31:16] == '0
				&& reg_wdata[15:0] <= CHANGE_BAND_MAX)
				binary_change_band <= reg_wdata[15:0];
			if (wr_hit(REG_SPARE))
				spare_word_seven <= reg_wdata[15:0];
		end
	end

	// a new error arriving with the clearing write wins, so it is never lost
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			error_report <= ERR_NONE;
		else if (error_valid)
			error_report <= error_code_in;
		else if (wr_hit(REG_ERROR))
			error_report <= ERR_NONE;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			reply_delay_ms <= RST_REPLY_DELAY;
		else if (wr_hit(REG_REPLY_DELAY) && reg_wdata[31:8] == '0)
			reply_delay_ms <= reg_wdata[7:0];
	end

	// reply delay sequencer
	assign delay_done = (ms_left == 8'h00);

	always_comb
	begin
		next_state = state;
		case (state)
			SPSB_IDLE:
				if (request_end && port_enable)
					next_state = SPSB_WAIT;
			SPSB_WAIT:
				if (!port_enable)
					next_state = SPSB_IDLE;
				else if (request_end)
					next_state = SPSB_WAIT;
				else if (delay_done)
					next_state = SPSB_READY;
			SPSB_READY:
				if (!port_enable || reply_start)
					next_state = SPSB_IDLE;
				else if (request_end)
					next_state = SPSB_WAIT;
			default:
				next_state = SPSB_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			state <= SPSB_IDLE;
		else
			state <= next_state;
	end

	// each request end restarts the count, so timing is from its last character
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ms_left  <= 8'h00;
			tick_cnt <= 32'h0000_0000;
		end
		else if (request_end)
		begin
			ms_left  <= reply_delay_ms;
			tick_cnt <= 32'h0000_0000;
		end
		else if (state == SPSB_WAIT && !delay_done)
		begin
			if (tick_cnt == CPM - 32'h0000_0001)
			begin
				tick_cnt <= 32'h0000_0000;
				ms_left  <= ms_left - 8'h01;
			end
			else
				tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	// sending is allowed only once the count has run out
	assign reply_permit = (state == SPSB_READY);
	assign reply_event  = (state == SPSB_WAIT) && (next_state == SPSB_READY);

	// interrupts: sticky, write one to clear, a new event beats the clear
	assign irq_set = {reply_event, error_valid};
	// strobe decoded in place: a continuous assign does not see signals read inside a function
	assign irq_clr = (reg_wr && reg_addr == REG_IRQ_STATUS) ? reg_wdata[IRQ_W-1:0] : '0;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			irq_status <= '0;
		else
			irq_status <= (irq_status & ~irq_clr) | irq_set;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			irq_mask <= '0;
		else if (wr_hit(REG_IRQ_MASK))
			irq_mask <= reg_wdata[IRQ_W-1:0];
	end

	assign irq = |(irq_status & irq_mask);

	// read mux; unmapped offsets read zero
	always_comb
	begin
		next_rdata = '0;
		case (reg_addr)
			REG_MODE:        next_rdata[2:0]       = protocol_mode;
			REG_BAUD:        next_rdata[3:0]       = baud_code;
			REG_GROUP:       next_rdata[2:0]       = group_address;
			REG_UNIT:        next_rdata[7:0]       = unit_address;
			REG_SUPPRESS:    next_rdata[0]         = ascii_suppress_flag;
			REG_CHANGE_BAND: next_rdata[15:0]      = binary_change_band;
			REG_SPARE:       next_rdata[15:0]      = spare_word_seven;
			REG_ERROR:       next_rdata[15:0]      = error_report;
			REG_REPLY_DELAY: next_rdata[7:0]       = reply_delay_ms;
			REG_IRQ_STATUS:  next_rdata[IRQ_W-1:0] = irq_status;
			REG_IRQ_MASK:    next_rdata[IRQ_W-1:0] = irq_mask;
			REG_PORT_STATUS:
			begin
				next_rdata[PST_WAIT]  = (state == SPSB_WAIT);
				next_rdata[PST_READY] = (state == SPSB_READY);
			end
			default:         next_rdata            = '0;
		endcase
	end

	// data only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= '0;
	end

endmodule : spsb_core

`default_nettype wire

//--- core/spsb_pkg.sv
// shared constants for the serial port setup block
package spsb_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] REG_MODE        = 8'h00;
	localparam logic [7:0] REG_BAUD        = 8'h04;
	localparam logic [7:0] REG_GROUP       = 8'h08;
	localparam logic [7:0] REG_UNIT        = 8'h0C;
	localparam logic [7:0] REG_SUPPRESS    = 8'h10;
	localparam logic [7:0] REG_CHANGE_BAND = 8'h14;
	localparam logic [7:0] REG_SPARE       = 8'h18;
	localparam logic [7:0] REG_ERROR       = 8'h1C;
	localparam logic [7:0] REG_REPLY_DELAY = 8'h20;
	localparam logic [7:0] REG_IRQ_STATUS  = 8'h24;
	localparam logic [7:0] REG_IRQ_MASK    = 8'h28;
	localparam logic [7:0] REG_PORT_STATUS = 8'h2C;

	// protocol mode codes
	typedef enum logic [2:0] {
		SPSB_MODE_DISABLED      = 3'h0,
		SPSB_MODE_REPEATER_MSTR = 3'h1,
		SPSB_MODE_REPEATER_SLV  = 3'h2,
		SPSB_MODE_ASCII         = 3'h3,
		SPSB_MODE_BINARY        = 3'h4
	} spsb_mode_t;

	localparam logic [2:0]  MODE_MAX        = 3'h4;
	localparam logic [3:0]  BAUD_CODE_MAX   = 4'h9;
	localparam logic [2:0]  GROUP_MAX       = 3'h7;
	localparam logic [15:0] CHANGE_BAND_MAX = 16'h2710;

	// reset values
	localparam logic [2:0]  RST_MODE        = 3'h3;
	localparam logic [3:0]  RST_BAUD        = 4'h5;
	localparam logic [2:0]  RST_GROUP       = 3'h0;
	localparam logic [7:0]  RST_UNIT        = 8'h00;
	localparam logic        RST_SUPPRESS    = 1'b1;
	localparam logic [15:0] RST_CHANGE_BAND = 16'h0000;
	localparam logic [15:0] RST_SPARE       = 16'hFFFF;
	localparam logic [15:0] ERR_NONE        = 16'h00C0;
	localparam logic [7:0]  RST_REPLY_DELAY = 8'h02;

	// interrupt bit positions
	localparam int unsigned IRQ_ERROR = 0;
	localparam int unsigned IRQ_REPLY = 1;
	localparam int unsigned IRQ_W     = 2;

	// port status bit positions
	localparam int unsigned PST_WAIT  = 0;
	localparam int unsigned PST_READY = 1;

	// timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned MS_IN_NS      = 1_000_000;
	localparam int unsigned DIV_W         = 20;

endpackage : spsb_pkg

//--- testbench/spsb_core_assertions.sv
// port assertions for the serial port setup block
`timescale 1ns/10ps
`default_nettype none
module spsb_core_assertions
	import spsb_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = 4
)(
	input wire logic              clk_sys,
	input wire logic              rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              request_end,
	input wire logic              reply_start,
	input wire logic              error_valid,
	input wire logic [15:0]       error_code_in,
	input wire logic              port_enable,
	input wire logic [2:0]        protocol_mode,
	input wire logic [3:0]        baud_code,
	input wire logic [DIV_W-1:0]  bit_divisor,
	input wire logic [2:0]        group_address,
	input wire logic [7:0]        unit_address,
	input wire logic              reply_permit,
	input wire logic              irq
);
	localparam int unsigned RATE [10] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400,
		57600, 115200};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	mode_write_a: assert property (reg_wr && reg_addr == REG_MODE && reg_wdata <= 32'h4
		|=> protocol_mode == $past(reg_wdata[2:0]) && port_enable == (protocol_mode != 3'h0))
		else $error("mode write not applied");
	rate_div_a: assert property (1'b1 |=>
		bit_divisor == DIV_W'(CLK_HZ / RATE[$past(baud_code)])) else $error("bad divisor");
	baud_refuse_a: assert property (reg_wr && reg_addr == REG_BAUD && reg_wdata > 32'h9
		|=> $stable(baud_code)) else $error("bad rate code taken");
	group_write_a: assert property (reg_wr && reg_addr == REG_GROUP |=> group_address ==
		(($past(reg_wdata) <= 32'h7) ? $past(reg_wdata[2:0]) : $past(group_address)))
		else $error("group address wrong");
	unit_write_a: assert property (reg_wr && reg_addr == REG_UNIT |=> unit_address ==
		(($past(reg_wdata) <= 32'hFF) ? $past(reg_wdata[7:0]) : $past(unit_address)))
		else $error("unit address wrong");
	err_clear_a: assert property (reg_wr && reg_addr == REG_ERROR && !error_valid ##1
		reg_rd && reg_addr == REG_ERROR && !error_valid |=> reg_rdata == {16'h0000, ERR_NONE})
		else $error("error code not cleared");
	err_read_a: assert property (error_valid ##1 reg_rd && reg_addr == REG_ERROR
		&& !error_valid |=> reg_rdata[15:0] == $past(error_code_in, 2))
		else $error("error code not readable");
	permit_restart_a: assert property (request_end && port_enable |=> !reply_permit)
		else $error("reply permitted without delay");
	cover property (reply_permit && reply_start);
	cover property (error_valid && irq);
	cover property (reg_wr && reg_addr == REG_MODE && reg_wdata == 32'h0);
endmodule : spsb_core_assertions
bind spsb_core spsb_core_assertions #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_chk (.*);
`default_nettype wire

//--- testbench/spsb_link_model.sv
// link engine stand-in: request ends, errors and reply starts
`timescale 1ns/10ps
`default_nettype none
module spsb_link_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        req_go,
	input  wire logic        err_go,
	input  wire logic [15:0] err_data,
	input  wire logic [7:0]  lag,
	input  wire logic        reply_permit,
	output logic             request_end,
	output logic             reply_start,
	output logic             error_valid,
	output logic      [15:0] error_code_in
);
	logic [7:0] wait_cnt;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{request_end, reply_start, error_valid, wait_cnt} <= '0;
			error_code_in <= 16'h0000;
		end
		else
		begin
			request_end <= req_go;
			error_valid <= err_go;
			// code is only held while valid, so it churns in between
			error_code_in <= err_go ? err_data : ~error_code_in;
			// lag FF means the reply never starts
			if (reply_permit && !reply_start && lag != 8'hFF)
			begin
				wait_cnt <= wait_cnt + 8'h01;
				reply_start <= (wait_cnt == lag);
			end
			else
			begin
				wait_cnt <= 8'h00;
				reply_start <= 1'b0;
			end
		end
	end
endmodule : spsb_link_model
`default_nettype wire

//--- testbench/tb_spsb_core.sv
// self-checking bench for the serial port setup block
`timescale 1ns/10ps
`default_nettype none
module tb_spsb_core;
	import spsb_pkg::*;
	localparam int unsigned CPM = 4;
	localparam int unsigned RATE [10] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400,
		57600, 115200};
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} spsb_row_t;
	logic             clk_sys, rst_b, reg_wr, reg_rd, req_go, err_go, irq;
	logic             request_end, reply_start, error_valid, port_enable, reply_permit;
	logic [7:0]       reg_addr, lag, unit_address;
	logic [31:0]      reg_wdata, reg_rdata, d;
	logic [15:0]      err_data, error_code_in;
	logic [2:0]       protocol_mode, group_address;
	logic [3:0]       baud_code;
	logic [DIV_W-1:0] bit_divisor;
	int               n_fail, total_checks, n, i;
	int               dly [3] = '{0, 2, 255};
	logic [31:0]      rst_val [11] = '{32'h3, 32'h5, 32'h0, 32'h0, 32'h1, 32'h0, 32'hFFFF,
		32'hC0, 32'h2, 32'h0, 32'h0};
	spsb_row_t        rows [14] = '{'{REG_MODE, 32'h4, 32'h4}, '{REG_MODE, 32'h5, 32'h4},
		'{REG_BAUD, 32'h9, 32'h9}, '{REG_BAUD, 32'hA, 32'h9}, '{REG_GROUP, 32'h7, 32'h7},
		'{REG_GROUP, 32'h8, 32'h7}, '{REG_UNIT, 32'hFF, 32'hFF}, '{REG_UNIT, 32'h100, 32'hFF},
		'{REG_SUPPRESS, 32'h0, 32'h0}, '{REG_CHANGE_BAND, 32'h2710, 32'h2710},
		'{REG_CHANGE_BAND, 32'h2711, 32'h2710}, '{REG_SPARE, 32'h1234, 32'h1234},
		'{REG_ERROR, 32'h5555, 32'hC0}, '{8'h40, 32'hFF, 32'h0}};

	spsb_core #(.CYCLES_PER_MS(CPM)) i_spsb_core (.*);
	spsb_link_model i_spsb_link_model (.*);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one bus cycle; strobes stay up until the next call so accesses run back to back
	task put(input logic w, input logic r, input logic [7:0] a, input logic [31:0] wd);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= wd;
		@(posedge clk_sys);
		#1 d = reg_rdata;
	endtask : put

	task measure(input int exp);
		req_go <= 1'b1;
		@(posedge clk_sys);
		#1 req_go <= 1'b0;
		@(posedge clk_sys);
		#1 n = 0;
		while (!reply_permit && n < 1100)
		begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk(n, exp);
	endtask : measure

	task give_verdict;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial
	begin
		#200_000;
		n_fail++;
		give_verdict;
	end

	initial
	begin
		{rst_b, reg_wr, reg_rd, req_go, err_go, reg_addr, reg_wdata, err_data} = '0;
		{n_fail, total_checks} = '0;
		lag = 8'hFF;
		repeat (20) @(posedge clk_sys);
		#1 rst_b <= 1'b1;
		foreach (rows[k])
		begin
			put(1'b1, 1'b0, rows[k].a, rows[k].w);
			put(1'b0, 1'b1, rows[k].a, 32'h0);
			chk(d, rows[k].e);
		end
		for (i = 0; i < 5; i++)
		begin
			put(1'b1, 1'b0, REG_MODE, i);
			chk(protocol_mode, i);
			chk(port_enable, i != 0);
		end
		for (i = 0; i < 10; i++)
		begin
			put(1'b1, 1'b0, REG_BAUD, i);
			put(1'b0, 1'b0, 8'h00, 32'h0);
			chk(bit_divisor, CLK_HZ / RATE[i]);
		end
		foreach (dly[k])
		begin
			put(1'b1, 1'b0, REG_REPLY_DELAY, dly[k]);
			put(1'b0, 1'b0, 8'h00, 32'h0);
			measure(dly[k] * CPM + 1);
			measure(dly[k] * CPM + 1);
			put(1'b0, 1'b1, REG_PORT_STATUS, 32'h0);
			chk(d, 32'h2);
		end
		lag <= 8'h03;
		n = 0;
		while (reply_permit && n < 20)
		begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk(reply_permit, 1'b0);
		lag <= 8'hFF;
		put(1'b1, 1'b0, REG_REPLY_DELAY, 32'h0);
		put(1'b1, 1'b0, REG_MODE, 32'h0);
		put(1'b0, 1'b0, 8'h00, 32'h0);
		req_go <= 1'b1;
		@(posedge clk_sys);
		#1 req_go <= 1'b0;
		repeat (12) @(posedge clk_sys);
		#1 chk(reply_permit, 1'b0);
		for (i = 1; i >= 0; i--)
		begin
			put(1'b1, 1'b0, REG_IRQ_MASK, i);
			put(1'b0, 1'b0, 8'h00, 32'h0);
			err_data <= 16'h1234 + i[15:0];
			err_go <= 1'b1;
			@(posedge clk_sys);
			#1 err_go <= 1'b0;
			@(posedge clk_sys);
			#1 chk(irq, i);
			put(1'b0, 1'b1, REG_ERROR, 32'h0);
			chk(d, 32'h1234 + i);
			put(1'b1, 1'b0, REG_IRQ_STATUS, 32'h1);
			put(1'b0, 1'b0, 8'h00, 32'h0);
			chk(irq, 1'b0);
		end
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk(bit_divisor, CLK_HZ / 9600);
		chk(reply_permit, 1'b0);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		#1;
		for (i = 0; i < 11; i++)
		begin
			put(1'b0, 1'b1, 8'(i * 4), 32'h0);
			chk(d, rst_val[i]);
		end
		put(1'b0, 1'b0, 8'h00, 32'h0);
		give_verdict;
	end
endmodule : tb_spsb_core
`default_nettype wire
